// >>> core/mq_reset_cfg.svh
// Purpose : Offsets, field positions, reset values and cycle counts of the reset control.
// Assumes : Included by bare name from every file that needs these figures.
// Notes   : Definitions only; no logic lives here.
`ifndef MQ_RESET_CFG_SVH
`define MQ_RESET_CFG_SVH

// ****************************************************************
// Register byte offsets on the bus.
// ****************************************************************
`define REG_CTRL      8'h00
`define REG_QSEL      8'h04
`define REG_PUSH      8'h08
`define REG_POP       8'h0C
`define REG_STATUS    8'h10
`define REG_OFFSET    8'h14
`define REG_LEVEL     8'h18

// ****************************************************************
// Field positions.
// ****************************************************************
`define CTRL_SERIAL_DONE  0
`define QSEL_WQ_LSB       0
`define QSEL_RQ_LSB       4
`define STRAP_OFFSET      0
`define STRAP_PROG_MODE   1
`define STATUS_STRAP_LSB  8

// ****************************************************************
// Reset values and cycle counts.
// ****************************************************************
`define RESET_WORD        32'h0000_0000
`define OFFSET_LOW        16'h0008
`define OFFSET_HIGH       16'h0080
`define SEL_STABLE_CYCLES 2'h2
`define PART_RECOV_CYCLES 2'h3
`define DEFAULT_LOAD_CYC  8'h10

`endif

// >>> core/mq_reset_pkg.sv
// Purpose : Types shared by the reset control files.
// Assumes : Nothing beyond the configuration header.
// Notes   : Used by scoped names only, never imported.
package mq_reset_pkg;

  // Life cycle of the device configuration.
  typedef enum logic [1:0] {
    UNCONF,
    MRESET,
    PROGRAM,
    READY
  } phase_type;

endpackage

// >>> core/ptr_if.sv
// Purpose : Carries pointer updates and pointer read-back between control and table.
// Assumes : Both sides run on the same clock.
// Notes   : Read-back lags the index by one clock edge.
`timescale 1ns/100ps
`default_nettype none

interface ptr_if #(
  parameter int QW    = 3,
  parameter int PTR_W = 13
);
  logic             clear_all;  // Clear the pointers of every queue.
  logic             clear_en;   // Clear the pointers of one queue.
  logic [QW-1:0]    clear_idx;  // Queue cleared by clear_en.
  logic             push_en;    // Advance a write pointer.
  logic [QW-1:0]    push_idx;   // Queue written.
  logic             pop_en;     // Advance a read pointer.
  logic [QW-1:0]    pop_idx;    // Queue read.
  logic [QW-1:0]    wsel_idx;   // Queue shown on the write side.
  logic [QW-1:0]    rsel_idx;   // Queue shown on the read side.
  logic [PTR_W-1:0] w_wptr;     // Write pointer of the write-side queue.
  logic [PTR_W-1:0] w_rptr;     // Read pointer of the write-side queue.
  logic [PTR_W-1:0] r_wptr;     // Write pointer of the read-side queue.
  logic [PTR_W-1:0] r_rptr;     // Read pointer of the read-side queue.

  modport ctrl (output clear_all, clear_en, clear_idx, push_en, push_idx, pop_en, pop_idx,
                output wsel_idx, rsel_idx, input w_wptr, w_rptr, r_wptr, r_rptr);
  modport store (input clear_all, clear_en, clear_idx, push_en, push_idx, pop_en, pop_idx,
                 input wsel_idx, rsel_idx, output w_wptr, w_rptr, r_wptr, r_rptr);
endinterface

`default_nettype wire

// >>> core/ptr_table.sv
// Purpose : Holds the read and write pointer of every queue.
// Assumes : At most one push and one pop per clock.
// Notes   : Read-back comes out of registers, one edge after the index.
`timescale 1ns/100ps
`default_nettype none

module ptr_table #(
  parameter int NQ    = 8,
  parameter int PTR_W = 13
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  ptr_if.store      io
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [NQ-1:0][PTR_W-1:0] wptr;   // Write pointers.
    logic [NQ-1:0][PTR_W-1:0] rptr;   // Read pointers.
    logic [PTR_W-1:0]         w_wptr; // Registered read-back, write side.
    logic [PTR_W-1:0]         w_rptr; // Registered read-back, write side.
    logic [PTR_W-1:0]         r_wptr; // Registered read-back, read side.
    logic [PTR_W-1:0]         r_rptr; // Registered read-back, read side.
  } tbl_type;

  tbl_type s_q;  // Present state.
  tbl_type s_d;  // Next state.

  // Each queue updates on its own; a clear wins over a push or pop in the same cycle.
  always_comb begin
    s_d = s_q;
    for (int q = 0; q < NQ; q++) begin
      if (io.clear_all || (io.clear_en && (int'(io.clear_idx) == q))) begin
        s_d.wptr[q] = '0;
        s_d.rptr[q] = '0;
      end else begin
        if (io.push_en && (int'(io.push_idx) == q)) begin
          s_d.wptr[q] = s_q.wptr[q] + 1'b1;
        end
        if (io.pop_en && (int'(io.pop_idx) == q)) begin
          s_d.rptr[q] = s_q.rptr[q] + 1'b1;
        end
      end
    end
    s_d.w_wptr = s_q.wptr[io.wsel_idx];
    s_d.w_rptr = s_q.rptr[io.wsel_idx];
    s_d.r_wptr = s_q.wptr[io.rsel_idx];
    s_d.r_rptr = s_q.rptr[io.rsel_idx];
  end

  // One register stage for the whole table.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign io.w_wptr = s_q.w_wptr;
  assign io.w_rptr = s_q.w_rptr;
  assign io.r_wptr = s_q.r_wptr;
  assign io.r_rptr = s_q.r_rptr;

endmodule // ptr_table

`default_nettype wire

// >>> core/multi_queue_reset_control.sv
// Purpose : Master and partial reset control of a multi-queue buffer, reached over AHB-Lite.
// Assumes : Reset and strap pins are asynchronous; the bus runs on hclk.
// Notes   : Every bus access has one wait state so flags settle between accesses.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mq_reset_cfg.svh"

// How it works
// - Master reset is a full low-high pulse.
// - Master reset wipes all setup and control.
// - Straps caught during master reset set behaviour.
// - No queue operation until programming completes.
// - Partial reset clears selected queue's two pointers.
// - Partial reset leaves configuration untouched.
// - Mode strap low serial, high default only.
// - Default offsets eight or 128 by strap.
// - Serial enable output low marks programming done.
module multi_queue_reset_control #(
  parameter int NQ    = 8,
  parameter int DEPTH = 4096
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        master_reset_n,
  input  wire logic        partial_reset_n,
  input  wire logic        flag_bus_mode_sel,
  input  wire logic        input_width_sel,
  input  wire logic        output_width_sel,
  input  wire logic        master_device_sel,
  input  wire logic [2:0]  device_id_bits,
  input  wire logic        prog_mode_sel,
  input  wire logic        flag_offset_sel,
  output logic             serial_enable_out_n,
  output logic             full_flag,
  output logic             output_valid_flag,
  output logic             almost_empty_flag,
  output logic             almost_full_flag
);

  localparam int QW    = $clog2(NQ);
  localparam int PTR_W = $clog2(DEPTH) + 1;
  localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [1:0]                mrst_sync;  // Master reset synchroniser.
    logic [1:0]                prst_sync;  // Partial reset synchroniser.
    logic [8:0]                strap_s1;   // Strap synchroniser, first stage.
    logic [8:0]                strap_s2;   // Strap synchroniser, second stage.
    logic                      prst_prev;  // Synchronised partial reset, one cycle old.
    mq_reset_pkg::phase_type   phase;      // Configuration life cycle.
    logic [8:0]                straps;     // Straps caught during master reset.
    logic [7:0]                load_cnt;   // Default load progress.
    logic [PTR_W-1:0]          ae_off;     // Almost-empty offset.
    logic [PTR_W-1:0]          af_off;     // Almost-full offset.
    logic [QW-1:0]             wq;         // Queue selected on the write side.
    logic [QW-1:0]             rq;         // Queue selected on the read side.
    logic [1:0]                stable_cnt; // Cycles the selection has stood.
    logic [1:0]                recov_cnt;  // Recovery cycles left after partial reset.
    logic                      ph_valid;   // Data phase pending.
    logic                      ph_write;   // Pending access is a write.
    logic [7:0]                ph_addr;    // Pending access offset.
    logic                      hreadyout;  // Bus ready.
    logic [31:0]               hrdata;     // Bus read data.
    logic                      done_n;     // Programming done, active low.
    logic                      full;       // Write-side queue full.
    logic                      valid;      // Read-side queue holds data.
    logic                      ae;         // Read-side queue almost empty.
    logic                      af;         // Write-side queue almost full.
  } state_type;

  state_type s_q;  // Present state.
  state_type s_d;  // Next state.

  ptr_if #(.QW(QW), .PTR_W(PTR_W)) pi ();

  logic             commit;    // Data phase takes effect this cycle.
  logic             wr_commit; // A write takes effect this cycle.
  logic             mrst_low;  // Master reset held, synchronised.
  logic             prst_now;  // Partial reset pin level, synchronised.
  logic             ops_ok;    // Enabled writes and reads are allowed.
  logic [PTR_W-1:0] wocc;      // Fill level of the write-side queue.
  logic [PTR_W-1:0] rocc;      // Fill level of the read-side queue.

  // Decoding shared by the read path and the write path.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    s_d          = s_q;
    pi.clear_all = 1'b0;
    pi.clear_en  = 1'b0;
    pi.clear_idx = s_q.wq;
    pi.push_en   = 1'b0;
    pi.push_idx  = s_q.wq;
    pi.pop_en    = 1'b0;
    pi.pop_idx   = s_q.rq;
    pi.wsel_idx  = s_q.wq;
    pi.rsel_idx  = s_q.rq;
    mrst_low     = !s_q.mrst_sync[1];
    prst_now     = s_q.prst_sync[1];
    commit       = s_q.ph_valid && !s_q.hreadyout;
    wr_commit    = commit && s_q.ph_write;
    wocc         = pi.w_wptr - pi.w_rptr;
    rocc         = pi.r_wptr - pi.r_rptr;
    ops_ok       = (s_q.phase == mq_reset_pkg::READY) && prst_now && (s_q.recov_cnt == 2'h0);

    // Pins pass two flops; only the second stage is read.
    s_d.mrst_sync = {s_q.mrst_sync[0], master_reset_n};
    s_d.prst_sync = {s_q.prst_sync[0], partial_reset_n};
    s_d.strap_s1 = {flag_bus_mode_sel, input_width_sel, output_width_sel, master_device_sel,
                    device_id_bits, prog_mode_sel, flag_offset_sel};
    s_d.strap_s2 = s_q.strap_s1;
    s_d.prst_prev = prst_now;

    // Flags follow the cleared pointers by themselves after a partial reset.
    s_d.full = (wocc == DEPTH_P);
    s_d.af   = (wocc >= (DEPTH_P - s_q.af_off));
    s_d.valid = (rocc != '0);
    s_d.ae   = (rocc <= s_q.ae_off);

    // Bus: take an address phase, then one wait cycle in which the access commits.
    s_d.hrdata = `RESET_WORD;
    if (commit) begin
      s_d.ph_valid  = 1'b0;
      s_d.hreadyout = 1'b1;
      if (!s_q.ph_write) begin
        if (hit(s_q.ph_addr, `REG_QSEL)) begin
          s_d.hrdata = 32'(s_q.wq) << `QSEL_WQ_LSB | 32'(s_q.rq) << `QSEL_RQ_LSB;
        end else if (hit(s_q.ph_addr, `REG_STATUS)) begin
          s_d.hrdata = {16'h0000, 7'h00, s_q.straps[0],
                        2'b00, (s_q.recov_cnt != 2'h0), s_q.af, s_q.ae, s_q.valid, s_q.full,
                        !s_q.done_n};
          s_d.hrdata[`STATUS_STRAP_LSB +: 9] = s_q.straps;
        end else if (hit(s_q.ph_addr, `REG_OFFSET)) begin
          s_d.hrdata = {16'(s_q.af_off), 16'(s_q.ae_off)};
        end else if (hit(s_q.ph_addr, `REG_LEVEL)) begin
          s_d.hrdata = 32'(rocc);
        end
      end
    end else if (hsel && htrans[1] && hready) begin
      s_d.ph_valid  = 1'b1;
      s_d.ph_write  = hwrite;
      s_d.ph_addr   = haddr[7:0];
      s_d.hreadyout = 1'b0;
    end

    // Enabled writes and reads are refused before programming and around partial reset.
    if (wr_commit && hit(s_q.ph_addr, `REG_PUSH) && ops_ok && !(wocc == DEPTH_P)) begin
      pi.push_en = 1'b1;
    end
    if (wr_commit && hit(s_q.ph_addr, `REG_POP) && ops_ok && (rocc != '0)) begin
      pi.pop_en = 1'b1;
    end

    // Selection age, saturating, for the partial reset guard.
    if (wr_commit && hit(s_q.ph_addr, `REG_QSEL) && (s_q.phase == mq_reset_pkg::READY)) begin
      s_d.wq = hwdata[`QSEL_WQ_LSB +: QW];
      s_d.rq = hwdata[`QSEL_RQ_LSB +: QW];
      if ((s_d.wq != s_q.wq) || (s_d.rq != s_q.rq)) begin
        s_d.stable_cnt = 2'h0;
      end
    end else if (s_q.stable_cnt < `SEL_STABLE_CYCLES) begin
      s_d.stable_cnt = s_q.stable_cnt + 2'h1;
    end

    // Partial reset acts on the falling edge, so a single low cycle is enough.
    if (s_q.prst_prev && !prst_now) begin
      if ((s_q.phase == mq_reset_pkg::READY) && (s_q.wq == s_q.rq) &&
          (s_q.stable_cnt >= `SEL_STABLE_CYCLES)) begin
        pi.clear_en  = 1'b1;
        pi.clear_idx = s_q.wq;
      end
    end else if (!s_q.prst_prev && prst_now) begin
      s_d.recov_cnt = `PART_RECOV_CYCLES;
    end else if (s_q.recov_cnt != 2'h0) begin
      s_d.recov_cnt = s_q.recov_cnt - 2'h1;
    end

    // Configuration life cycle; a low master reset overrides everything.
    if (mrst_low) begin
      s_d.phase      = mq_reset_pkg::MRESET;
      s_d.straps     = s_q.strap_s2;
      s_d.ae_off     = '0;
      s_d.af_off     = '0;
      s_d.wq         = '0;
      s_d.rq         = '0;
      s_d.stable_cnt = 2'h0;
      s_d.recov_cnt  = 2'h0;
      s_d.load_cnt   = 8'h00;
      s_d.done_n     = 1'b1;
      pi.clear_all   = 1'b1;
      pi.push_en     = 1'b0;
      pi.pop_en      = 1'b0;
    end else begin
      case (s_q.phase)
        mq_reset_pkg::UNCONF: begin
          s_d.phase = mq_reset_pkg::UNCONF;
        end
        mq_reset_pkg::MRESET: begin
          s_d.phase = mq_reset_pkg::PROGRAM;
        end
        mq_reset_pkg::PROGRAM: begin
          if (s_q.straps[`STRAP_PROG_MODE]) begin
            // Default mode loads itself over a fixed number of cycles.
            s_d.load_cnt = s_q.load_cnt + 8'h01;
            if (s_q.load_cnt == `DEFAULT_LOAD_CYC) begin
              s_d.ae_off = s_q.straps[`STRAP_OFFSET] ? PTR_W'(`OFFSET_HIGH)
                                                     : PTR_W'(`OFFSET_LOW);
              s_d.af_off = s_d.ae_off;
              s_d.phase  = mq_reset_pkg::READY;
              s_d.done_n = 1'b0;
            end
          end else if (wr_commit) begin
            // Serial mode: software loads offsets, then reports the load finished.
            if (hit(s_q.ph_addr, `REG_OFFSET)) begin
              s_d.ae_off = PTR_W'(hwdata[15:0]);
              s_d.af_off = PTR_W'(hwdata[31:16]);
            end else if (hit(s_q.ph_addr, `REG_CTRL) && hwdata[`CTRL_SERIAL_DONE]) begin
              s_d.phase  = mq_reset_pkg::READY;
              s_d.done_n = 1'b0;
            end
          end
        end
        mq_reset_pkg::READY: begin
          s_d.done_n = 1'b0;
        end
        default: begin
          s_d.phase = mq_reset_pkg::UNCONF;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // The reset value marks an unconfigured device until a master reset pulse is seen.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.mrst_sync <= 2'b11;
      s_q.prst_sync <= 2'b11;
      s_q.prst_prev <= 1'b1;
      s_q.phase     <= mq_reset_pkg::UNCONF;
      s_q.hreadyout <= 1'b1;
      s_q.done_n    <= 1'b1;
      s_q.ae        <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Pointer table and outputs.
  // ****************************************************************
  ptr_table #(.NQ(NQ), .PTR_W(PTR_W)) u_table (
    .hclk    (hclk),
    .hresetn (hresetn),
    .io      (pi.store)
  );

  assign hreadyout           = s_q.hreadyout;
  assign hresp               = 1'b0;
  assign hrdata              = s_q.hrdata;
  assign serial_enable_out_n = s_q.done_n;
  assign full_flag           = s_q.full;
  assign output_valid_flag   = s_q.valid;
  assign almost_empty_flag   = s_q.ae;
  assign almost_full_flag    = s_q.af;

endmodule // multi_queue_reset_control

`default_nettype wire

// >>> dv/mq_reset_props.sv
// Purpose : Port-level checks of the reset control.
// Assumes : Bench selects the same queue on both sides before a partial reset.
// Notes   : One clock, so default clocking and disable are used.
`timescale 1ns/100ps
`default_nettype none
module mq_reset_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        master_reset_n,
  input wire logic        partial_reset_n,
  input wire logic        prog_mode_sel,
  input wire logic        serial_enable_out_n,
  input wire logic        full_flag,
  input wire logic        output_valid_flag,
  input wire logic        almost_empty_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // An accepted address phase, and a partial reset pulse once programmed.
  sequence addr_taken; hsel && htrans[1] && hready && hreadyout; endsequence
  sequence part_pulse; !serial_enable_out_n && $fell(partial_reset_n) ##1 !partial_reset_n;
  endsequence
  a_one_wait: assert property (addr_taken |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  a_mreset_done: assert property ((!master_reset_n)[*5] |-> serial_enable_out_n)
    else $error("programmed indication during master reset");
  a_mreset_empty: assert property ((!master_reset_n)[*6] |-> ##2
    (almost_empty_flag && !output_valid_flag && !full_flag)) else $error("queues not cleared");
  a_done_cause: assert property ($fell(serial_enable_out_n) |-> $past(master_reset_n, 3))
    else $error("programmed without a complete master reset");
  a_no_early_op: assert property (serial_enable_out_n |-> !$rose(output_valid_flag))
    else $error("queue written before programming");
  a_default_done: assert property ($rose(master_reset_n) && prog_mode_sel |->
    serial_enable_out_n[*8] ##[4:22] !serial_enable_out_n) else $error("default load time");
  a_serial_wait: assert property ($rose(master_reset_n) && !prog_mode_sel |->
    serial_enable_out_n[*8]) else $error("serial mode finished by itself");
  a_part_clear: assert property (part_pulse |-> ##[1:8]
    (!output_valid_flag && almost_empty_flag && !full_flag)) else $error("queue not emptied");
  a_part_keep: assert property (part_pulse |-> (!serial_enable_out_n)[*8])
    else $error("partial reset disturbed configuration");
endmodule // mq_reset_props
bind multi_queue_reset_control mq_reset_props i_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
  .prog_mode_sel(prog_mode_sel), .serial_enable_out_n(serial_enable_out_n),
  .full_flag(full_flag), .output_valid_flag(output_valid_flag),
  .almost_empty_flag(almost_empty_flag));
`default_nettype wire

// >>> dv/mq_host_model.sv
// Purpose : Host logic that drives the reset pins and the straps.
// Assumes : Tasks are entered just after a rising edge.
// Notes   : Straps move once master reset is over, so a late capture shows up.
`timescale 1ns/100ps
`default_nettype none
module mq_host_model (
  input  wire logic      hclk,
  output var  logic      master_reset_n,
  output var  logic      partial_reset_n,
  output var  logic [8:0] straps
);
  initial begin
    master_reset_n  = 1'h1;
    partial_reset_n = 1'h1;
    straps          = 9'h000;
  end
  // Straps stay fixed across the whole low pulse.
  task automatic master_pulse(input logic [8:0] s);
    straps         <= s;
    master_reset_n <= 1'h0;
    repeat (6) @(posedge hclk);
    master_reset_n <= 1'h1;
    repeat (4) @(posedge hclk);
    straps         <= ~s;
  endtask
  // Selection has settled beforehand; the pulse and the wait cover the sync lag.
  task automatic partial_pulse();
    repeat (3) @(posedge hclk);
    partial_reset_n <= 1'h0;
    repeat (2) @(posedge hclk);
    partial_reset_n <= 1'h1;
    repeat (6) @(posedge hclk);
  endtask
endmodule // mq_host_model
`default_nettype wire

// >>> dv/multi_queue_reset_control_tb.sv
// Purpose : Self-checking bench of the reset control.
// Assumes : One wait state per bus access, as the design promises.
// Notes   : Reads note their expectation in a queue; a monitor compares.
`timescale 1ns/100ps
`default_nettype none
`include "mq_reset_cfg.svh"
module multi_queue_reset_control_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, rd_pend, mrst_n, prst_n, done_n, hresp;
  logic        f_full, f_valid, f_aempty, f_afull;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, s;
  logic [8:0]  st, st9;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  int          n_errors, checked, cyc, seed;
  multi_queue_reset_control #(.NQ(8), .DEPTH(4096)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .master_reset_n(mrst_n), .partial_reset_n(prst_n), .flag_bus_mode_sel(st[8]),
    .input_width_sel(st[7]), .output_width_sel(st[6]), .master_device_sel(st[5]),
    .device_id_bits(st[4:2]), .prog_mode_sel(st[1]), .flag_offset_sel(st[0]),
    .serial_enable_out_n(done_n), .full_flag(f_full), .output_valid_flag(f_valid),
    .almost_empty_flag(f_aempty), .almost_full_flag(f_afull));
  mq_host_model i_host (.hclk(hclk), .master_reset_n(mrst_n), .partial_reset_n(prst_n),
    .straps(st));
  always #50 hclk = ~hclk;
  // ********
  // Checking and closing.
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Read data counts only in the data cycle that ends with ready high.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (rd_pend && hreadyout === 1'h1) begin
      chk(nm_q.pop_front(), hrdata, exp_q.pop_front());
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
    end
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  // One single word transfer; for a read, d is the expected data.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel    <= 1'h0;
    htrans  <= 2'h0;
    hwdata  <= w ? d : 32'h0000_0000;
    rd_pend <= !w;
    if (!w) begin
      exp_q.push_back(d);
      nm_q.push_back(nm);
    end
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd_pend <= 1'h0;
  endtask
  // ********
  // Main sequence.
  // ********
  initial begin
    seed = 32'hdc58; hclk = 1'h0; hresetn = 1'h0; hsel = 1'h0; htrans = 2'h0; hwrite = 1'h0;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; hsize = 3'h2; rd_pend = 1'h0;
    n_errors = 0; checked = 0; cyc = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk("prog_done_n", {31'h0, done_n}, 32'h0000_0001);
    acc(1'h0, 8'h1C, 32'h0000_0000, "unmapped");
    for (int m = 0; m < 2; m++) begin
      s = $random(seed);
      st9 = {s[8:2], 1'h1, m[0]};
      i_host.master_pulse(st9);
      acc(1'h1, `REG_PUSH, s, "");
      acc(1'h1, `REG_OFFSET, 32'h0033_0033, "");
      for (int k = 0; k < 40 && done_n !== 1'h0; k++) @(posedge hclk);
      chk("prog_done_n", {31'h0, done_n}, 32'h0000_0000);
      acc(1'h0, `REG_LEVEL, 32'h0000_0000, "level");
      acc(1'h0, `REG_OFFSET, m ? 32'h0080_0080 : 32'h0008_0008, "offset");
      acc(1'h0, `REG_STATUS, {15'h0, st9, 8'h09}, "status");
      $display("default mode test %0d done", m);
    end
    acc(1'h1, `REG_QSEL, 32'h0000_0055, "");
    acc(1'h0, `REG_QSEL, 32'h0000_0055, "qsel");
    acc(1'h1, `REG_PUSH, $random(seed), "");
    acc(1'h1, `REG_QSEL, 32'h0000_0022, "");
    repeat (3) acc(1'h1, `REG_PUSH, $random(seed), "");
    acc(1'h0, `REG_LEVEL, 32'h0000_0003, "level");
    i_host.partial_pulse();
    acc(1'h0, `REG_LEVEL, 32'h0000_0000, "level");
    acc(1'h0, `REG_STATUS, {15'h0, st9, 8'h09}, "status");
    acc(1'h0, `REG_OFFSET, 32'h0080_0080, "offset");
    acc(1'h1, `REG_PUSH, $random(seed), "");
    acc(1'h0, `REG_LEVEL, 32'h0000_0001, "level");
    acc(1'h1, `REG_QSEL, 32'h0000_0055, "");
    acc(1'h0, `REG_LEVEL, 32'h0000_0001, "level");
    $display("partial reset test done");
    st9 = {s[8:2], 2'h0};
    i_host.master_pulse(st9);
    repeat (6) @(posedge hclk);
    chk("prog_done_n", {31'h0, done_n}, 32'h0000_0001);
    // A large almost-full offset lets a single word raise the almost-full flag.
    acc(1'h1, `REG_OFFSET, 32'h0fff_0010, "");
    acc(1'h1, `REG_CTRL, 32'h0000_0001, "");
    @(posedge hclk);
    chk("prog_done_n", {31'h0, done_n}, 32'h0000_0000);
    acc(1'h0, `REG_OFFSET, 32'h0fff_0010, "offset");
    acc(1'h0, `REG_STATUS, {15'h0, st9, 8'h09}, "status");
    acc(1'h1, `REG_PUSH, $random(seed), "");
    acc(1'h0, `REG_STATUS, {15'h0, st9, 8'h1d}, "status");
    chk("flag_pins", {28'h0, f_full, f_valid, f_aempty, f_afull}, 32'h0000_0007);
    acc(1'h1, `REG_POP, 32'h0000_0000, "");
    acc(1'h0, `REG_LEVEL, 32'h0000_0000, "level");
    $display("serial mode test done");
    repeat (3) @(posedge hclk);
    wrap_up();
  end
endmodule // multi_queue_reset_control_tb
`default_nettype wire
